//--- common/gpb_cfg.svh
// register indices, field positions, reset values for the gpio ports
// assumes a word-aligned bus: byte address is four times the index
`ifndef GPB_CFG_SVH
`define GPB_CFG_SVH

`define GPB_IDX_ANALOG_LATCH 10'h001
`define GPB_IDX_CLOCK_LATCH 10'h002
`define GPB_IDX_TIMER_LATCH 10'h003
`define GPB_IDX_ANALOG_DIR 10'h005
`define GPB_IDX_CLOCK_DIR 10'h006
`define GPB_IDX_TIMER_DIR 10'h007
`define GPB_IDX_TIMER_PULLUP 10'h008

`define GPB_CLOCK_PINS 6
`define GPB_CLOCK_MASK 8'h3F
`define GPB_CLKOUT_BIT 7
`define GPB_CLKOUT_PIN 2
`define GPB_TA_CLK_PIN 6
`define GPB_TB_CLK_PIN 4
`define GPB_PS_EXTERNAL 3'h7
`define GPB_CONV_PINS 5'h08

`define GPB_DIR_RESET 8'h00
`define GPB_CLKOUT_RESET 1'h0
`define GPB_PULLUP_RESET 8'h00

`endif

//--- common/gpb_pkg.sv
// types shared by the gpio port logic
// assumes gpb_cfg.svh holds the numbers
package gpb_pkg;
    typedef logic [7:0] gpb_byte_t;
    // one-hot register select decoded from the bus address
    typedef enum logic [7:0] {
        GPB_SEL_NONE = 8'h00,
        GPB_SEL_ALATCH = 8'h01,
        GPB_SEL_CLATCH = 8'h02,
        GPB_SEL_TLATCH = 8'h04,
        GPB_SEL_ADIR = 8'h08,
        GPB_SEL_CDIR = 8'h10,
        GPB_SEL_TDIR = 8'h20,
        GPB_SEL_TPULL = 8'h40
    } gpb_sel_e;
endpackage : gpb_pkg

//--- core/gpb_ports.sv
// three gpio ports behind an ahb-lite slave: analog-shared, clock-out
// and timer-clock ports. assumes a single slave with zero wait states,
// converter and timer controls on sys_clk, pins asynchronous.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
`include "gpb_cfg.svh"

module gpb_ports (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] analog_port_pin_in,
    output logic [7:0] analog_port_pin_out,
    output logic [7:0] analog_port_pin_oe,
    input wire logic [5:0] clock_port_pin_in,
    output logic [5:0] clock_port_pin_out,
    output logic [5:0] clock_port_pin_oe,
    input wire logic [7:0] timer_port_pin_in,
    output logic [7:0] timer_port_pin_out,
    output logic [7:0] timer_port_pin_oe,
    output logic [7:0] timer_port_pullup_on,
    input wire logic [4:0] converter_channel_select,
    output logic [7:0] converter_input_pin,
    input wire logic [2:0] timer_a_prescaler_select,
    input wire logic [2:0] timer_b_prescaler_select,
    output logic timer_a_external_clock,
    output logic timer_b_external_clock
);

    // data latches, deliberately without reset
    gpb_pkg::gpb_byte_t analog_port_latch;
    gpb_pkg::gpb_byte_t clock_port_latch;
    gpb_pkg::gpb_byte_t timer_port_latch;
    gpb_pkg::gpb_byte_t next_analog_port_latch;
    gpb_pkg::gpb_byte_t next_clock_port_latch;
    gpb_pkg::gpb_byte_t next_timer_port_latch;

    // control state, reset
    gpb_pkg::gpb_byte_t analog_port_dir;
    gpb_pkg::gpb_byte_t clock_port_dir;
    gpb_pkg::gpb_byte_t timer_port_dir;
    gpb_pkg::gpb_byte_t timer_port_pullup_enable;
    logic system_clock_out_enable;
    gpb_pkg::gpb_byte_t next_analog_port_dir;
    gpb_pkg::gpb_byte_t next_clock_port_dir;
    gpb_pkg::gpb_byte_t next_timer_port_dir;
    gpb_pkg::gpb_byte_t next_timer_port_pullup_enable;
    logic next_system_clock_out_enable;

    // bus data-phase state
    gpb_pkg::gpb_sel_e wr_sel;
    gpb_pkg::gpb_sel_e next_wr_sel;
    logic [31:0] next_hrdata;

    // synchronisers: stage one feeds stage two only
    logic [7:0] analog_sync1;
    logic [7:0] analog_sync2;
    logic [5:0] clock_sync1;
    logic [5:0] clock_sync2;
    logic [7:0] timer_sync1;
    logic [7:0] timer_sync2;

    // registered pin controls, and the unregistered clock pin drive
    logic [7:0] next_analog_oe;
    logic [5:0] next_clock_oe;
    logic [7:0] next_timer_oe;
    logic [7:0] next_pullup_on;
    logic [7:0] next_conv_pin;
    logic next_ta_clk;
    logic next_tb_clk;
    logic [5:0] clock_drive;

    gpb_pkg::gpb_sel_e addr_sel;
    logic bus_take;
    gpb_pkg::gpb_byte_t wbyte;
    gpb_pkg::gpb_byte_t analog_view;
    gpb_pkg::gpb_byte_t clock_view;
    gpb_pkg::gpb_byte_t timer_view;

    // address decode on the word index; anything else is unmapped
    always_comb begin
        unique case (haddr[11:2])
            `GPB_IDX_ANALOG_LATCH: addr_sel = gpb_pkg::GPB_SEL_ALATCH;
            `GPB_IDX_CLOCK_LATCH: addr_sel = gpb_pkg::GPB_SEL_CLATCH;
            `GPB_IDX_TIMER_LATCH: addr_sel = gpb_pkg::GPB_SEL_TLATCH;
            `GPB_IDX_ANALOG_DIR: addr_sel = gpb_pkg::GPB_SEL_ADIR;
            `GPB_IDX_CLOCK_DIR: addr_sel = gpb_pkg::GPB_SEL_CDIR;
            `GPB_IDX_TIMER_DIR: addr_sel = gpb_pkg::GPB_SEL_TDIR;
            `GPB_IDX_TIMER_PULLUP: addr_sel = gpb_pkg::GPB_SEL_TPULL;
            default: addr_sel = gpb_pkg::GPB_SEL_NONE;
        endcase
    end

    assign bus_take = hsel & htrans[1] & hready;
    assign wbyte = hwdata[7:0];

    always_comb begin
        next_analog_port_latch = analog_port_latch;
        next_clock_port_latch = clock_port_latch;
        next_timer_port_latch = timer_port_latch;
        next_analog_port_dir = analog_port_dir;
        next_clock_port_dir = clock_port_dir;
        next_timer_port_dir = timer_port_dir;
        next_timer_port_pullup_enable = timer_port_pullup_enable;
        next_system_clock_out_enable = system_clock_out_enable;
        next_wr_sel = gpb_pkg::GPB_SEL_NONE;
        next_hrdata = hrdata;
        unique case (wr_sel)
            gpb_pkg::GPB_SEL_ALATCH: next_analog_port_latch = wbyte;
            gpb_pkg::GPB_SEL_CLATCH: begin
                next_clock_port_latch = wbyte & `GPB_CLOCK_MASK;
            end
            gpb_pkg::GPB_SEL_TLATCH: next_timer_port_latch = wbyte;
            gpb_pkg::GPB_SEL_ADIR: next_analog_port_dir = wbyte;
            gpb_pkg::GPB_SEL_CDIR: begin
                next_clock_port_dir = wbyte & `GPB_CLOCK_MASK;
                next_system_clock_out_enable = wbyte[`GPB_CLKOUT_BIT];
            end
            gpb_pkg::GPB_SEL_TDIR: next_timer_port_dir = wbyte;
            gpb_pkg::GPB_SEL_TPULL: next_timer_port_pullup_enable = wbyte;
            gpb_pkg::GPB_SEL_NONE: begin
            end
            default: begin
            end
        endcase
        // read views use next values so a read right after a write is fresh
        // latch where output, pin where input
        // only the second synchroniser stage is read
        analog_view = (next_analog_port_dir & next_analog_port_latch)
            | (~next_analog_port_dir & analog_sync2);
        clock_view = (next_clock_port_dir & next_clock_port_latch)
            | (~next_clock_port_dir & {2'h0, clock_sync2});
        timer_view = (next_timer_port_dir & next_timer_port_latch)
            | (~next_timer_port_dir & timer_sync2);
        if (bus_take) begin
            next_hrdata = 32'h00000000;
            if (hwrite) begin
                next_wr_sel = addr_sel;
            end else begin
                unique case (addr_sel)
                    gpb_pkg::GPB_SEL_ALATCH: next_hrdata[7:0] = analog_view;
                    gpb_pkg::GPB_SEL_CLATCH: next_hrdata[7:0] = clock_view;
                    gpb_pkg::GPB_SEL_TLATCH: next_hrdata[7:0] = timer_view;
                    gpb_pkg::GPB_SEL_ADIR: begin
                        next_hrdata[7:0] = next_analog_port_dir;
                    end
                    gpb_pkg::GPB_SEL_CDIR: begin
                        next_hrdata[7:0] = next_clock_port_dir;
                        next_hrdata[`GPB_CLKOUT_BIT] =
                            next_system_clock_out_enable;
                    end
                    gpb_pkg::GPB_SEL_TDIR: begin
                        next_hrdata[7:0] = next_timer_port_dir;
                    end
                    gpb_pkg::GPB_SEL_TPULL: begin
                        next_hrdata[7:0] = next_timer_port_pullup_enable;
                    end
                    gpb_pkg::GPB_SEL_NONE: begin
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // pin control, registered so every control output comes from a flop
    always_comb begin
        next_conv_pin = 8'h00;
        // channel below eight claims that pin for the converter
        if (converter_channel_select < `GPB_CONV_PINS) begin
            next_conv_pin[converter_channel_select[2:0]] = 1'b1;
        end
        next_analog_oe = analog_port_dir & ~next_conv_pin;
        next_clock_oe = clock_port_dir[5:0];
        // clock output needs the buffer on
        if (system_clock_out_enable) begin
            next_clock_oe[`GPB_CLKOUT_PIN] = 1'b1;
        end
        next_timer_oe = timer_port_dir;
        next_pullup_on = timer_port_pullup_enable & ~timer_port_dir;
        // timer a clock from pin 6
        next_ta_clk = (timer_a_prescaler_select == `GPB_PS_EXTERNAL)
            & timer_sync2[`GPB_TA_CLK_PIN];
        // timer b clock from pin 4
        next_tb_clk = (timer_b_prescaler_select == `GPB_PS_EXTERNAL)
            & timer_sync2[`GPB_TB_CLK_PIN];
    end

    // latches keep their contents across reset
    always_ff @(posedge sys_clk) begin
        analog_port_latch <= next_analog_port_latch;
        clock_port_latch <= next_clock_port_latch;
        timer_port_latch <= next_timer_port_latch;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            analog_port_dir <= `GPB_DIR_RESET;
            clock_port_dir <= `GPB_DIR_RESET;
            timer_port_dir <= `GPB_DIR_RESET;
            system_clock_out_enable <= `GPB_CLKOUT_RESET;
            timer_port_pullup_enable <= `GPB_PULLUP_RESET;
            wr_sel <= gpb_pkg::GPB_SEL_NONE;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            analog_sync1 <= 8'h00;
            analog_sync2 <= 8'h00;
            clock_sync1 <= 6'h00;
            clock_sync2 <= 6'h00;
            timer_sync1 <= 8'h00;
            timer_sync2 <= 8'h00;
            analog_port_pin_oe <= 8'h00;
            clock_port_pin_oe <= 6'h00;
            timer_port_pin_oe <= 8'h00;
            timer_port_pullup_on <= 8'h00;
            converter_input_pin <= 8'h00;
            timer_a_external_clock <= 1'b0;
            timer_b_external_clock <= 1'b0;
        end else begin
            analog_port_dir <= next_analog_port_dir;
            clock_port_dir <= next_clock_port_dir;
            timer_port_dir <= next_timer_port_dir;
            system_clock_out_enable <= next_system_clock_out_enable;
            timer_port_pullup_enable <= next_timer_port_pullup_enable;
            wr_sel <= next_wr_sel;
            hrdata <= next_hrdata;
            // zero wait states, always okay
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            analog_sync1 <= analog_port_pin_in;
            analog_sync2 <= analog_sync1;
            clock_sync1 <= clock_port_pin_in;
            clock_sync2 <= clock_sync1;
            timer_sync1 <= timer_port_pin_in;
            timer_sync2 <= timer_sync1;
            analog_port_pin_oe <= next_analog_oe;
            clock_port_pin_oe <= next_clock_oe;
            timer_port_pin_oe <= next_timer_oe;
            timer_port_pullup_on <= next_pullup_on;
            converter_input_pin <= next_conv_pin;
            timer_a_external_clock <= next_ta_clk;
            timer_b_external_clock <= next_tb_clk;
        end
    end

    // latch values drive the pins directly; the clock pin is the exception
    always_comb begin
        clock_drive = clock_port_latch[5:0];
        // pin 2 carries sys_clk itself; a flop could only halve it
        // so this output is a mux and may glitch when the enable changes
        if (system_clock_out_enable) begin
            clock_drive[`GPB_CLKOUT_PIN] = sys_clk;
        end
    end

    assign analog_port_pin_out = analog_port_latch;
    assign clock_port_pin_out = clock_drive;
    assign timer_port_pin_out = timer_port_latch;

endmodule : gpb_ports

//--- verification/gpb_ports_asserts.sv
// timing checks on the gpio port block, seen from its ports only
// assumes one clock domain and the asynchronous active-high reset
`timescale 1ns/10ps
module gpb_ports_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [7:0] analog_port_pin_oe,
    input wire logic [5:0] clock_port_pin_oe,
    input wire logic [7:0] timer_port_pin_in,
    input wire logic [7:0] timer_port_pin_oe,
    input wire logic [7:0] timer_port_pullup_on,
    input wire logic [4:0] converter_channel_select,
    input wire logic [7:0] converter_input_pin,
    input wire logic [2:0] timer_a_prescaler_select,
    input wire logic [2:0] timer_b_prescaler_select,
    input wire logic timer_a_external_clock,
    input wire logic timer_b_external_clock
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // address phase of a timer direction write, then its data phase
    sequence s_tdir_wr;
        hsel && htrans[1] && hready && hwrite && haddr[11:2] == 10'h007 ##1 1;
    endsequence
    // synchroniser has run three clean edges since reset
    sequence s_warm;
        !$past(rst) && !$past(rst, 2) && !$past(rst, 3);
    endsequence
    // the edge that ends reset still sees rst high, so skip that attempt
    a_conv_pick: assert property (!rst &&
        converter_channel_select < 5'h08 |=>
        converter_input_pin == 8'h01 << $past(converter_channel_select[2:0]))
        else $error("converter pin not claimed");
    a_conv_none: assert property (converter_channel_select >= 5'h08 |=>
        converter_input_pin == 8'h00) else $error("converter claims a pin");
    a_claim_hiz: assert property (
        (converter_input_pin & analog_port_pin_oe) == 8'h00)
        else $error("claimed analog pin still driven");
    // register loads at the end of the data phase, oe one edge later
    a_dir_drive: assert property (s_tdir_wr |=> ##1
        timer_port_pin_oe == $past(hwdata[7:0], 2))
        else $error("oe not from dir");
    a_pullup_input: assert property (
        (timer_port_pullup_on & timer_port_pin_oe) == 8'h00)
        else $error("pullup on an output pin");
    a_tmra_clk: assert property (s_warm |-> timer_a_external_clock ==
        ($past(timer_a_prescaler_select) == 3'h7 && $past(timer_port_pin_in[6], 3)))
        else $error("timer a clock wrong");
    a_tmrb_clk: assert property (s_warm |-> timer_b_external_clock ==
        ($past(timer_b_prescaler_select) == 3'h7 && $past(timer_port_pin_in[4], 3)))
        else $error("timer b clock wrong");
    a_reset_dirs: assert property ($fell(rst) |-> analog_port_pin_oe == 8'h00 &&
        clock_port_pin_oe == 6'h00 && timer_port_pin_oe == 8'h00)
        else $error("pin driven after reset");
endmodule : gpb_ports_asserts

bind gpb_ports gpb_ports_asserts gpb_ports_asserts_i (
    .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .analog_port_pin_oe, .clock_port_pin_oe, .timer_port_pin_in,
    .timer_port_pin_oe, .timer_port_pullup_on, .converter_channel_select,
    .converter_input_pin, .timer_a_prescaler_select,
    .timer_b_prescaler_select, .timer_a_external_clock, .timer_b_external_clock
);

//--- verification/gpb_pin_model.sv
// board side of the port pins: outside drivers and timer port pullups
// assumes outside drivers only act on pins the block has released
`timescale 1ns/10ps
module gpb_pin_model (
    input wire logic sys_clk,
    input wire logic [7:0] a_out,
    input wire logic [7:0] a_oe,
    input wire logic [5:0] c_out,
    input wire logic [5:0] c_oe,
    input wire logic [7:0] t_out,
    input wire logic [7:0] t_oe,
    input wire logic [7:0] t_pull,
    input wire logic [7:0] a_ext,
    input wire logic [5:0] c_ext,
    input wire logic [7:0] t_ext,
    input wire logic [7:0] t_ext_on,
    output logic [7:0] a_lvl,
    output logic [5:0] c_lvl,
    output logic [7:0] t_lvl
);
    logic [7:0] t_last;
    // driven bits show the block, released bits the outside
    assign a_lvl = (a_oe & a_out) | (~a_oe & a_ext);
    assign c_lvl = (c_oe & c_out) | (~c_oe & c_ext);
    // a floating pin sits high on its pullup, else it wanders
    assign t_lvl = (t_oe & t_out) | (~t_oe & t_ext_on & t_ext)
        | (~t_oe & ~t_ext_on & (t_pull | ~t_last));
    always_ff @(posedge sys_clk) begin
        t_last <= t_lvl;
    end
endmodule : gpb_pin_model

//--- verification/gpio_ports_bcd_tb.sv
// self-checking bench for the three gpio ports behind ahb-lite
// assumes the zero-wait slave and the pin model beside it
`timescale 1ns/10ps
module gpio_ports_bcd_tb;
    logic sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, v, v2;
    logic [1:0] htrans = 2'h0;
    logic hready, hresp, ta_clk, tb_clk;
    logic [7:0] a_in, a_out, a_oe, t_in, t_out, t_oe, pull_on, conv;
    logic [5:0] c_in, c_out, c_oe, c_ext = 6'h0;
    logic [7:0] a_ext = 8'h0, t_ext = 8'h0, t_ext_on = 8'hFF;
    logic [7:0] lat, dir, pu, claim, tlev;
    logic [4:0] sel = 5'h1F;
    logic [2:0] psa = 3'h0, psb = 3'h0;
    integer seed = 32'h880EFC0D, err_total = 0, compares = 0, cyc = 0;

    gpb_ports gpb_ports_i (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
        .analog_port_pin_in(a_in), .analog_port_pin_out(a_out),
        .analog_port_pin_oe(a_oe), .clock_port_pin_in(c_in),
        .clock_port_pin_out(c_out), .clock_port_pin_oe(c_oe),
        .timer_port_pin_in(t_in), .timer_port_pin_out(t_out),
        .timer_port_pin_oe(t_oe), .timer_port_pullup_on(pull_on),
        .converter_channel_select(sel), .converter_input_pin(conv),
        .timer_a_prescaler_select(psa), .timer_b_prescaler_select(psb),
        .timer_a_external_clock(ta_clk), .timer_b_external_clock(tb_clk));
    gpb_pin_model gpb_pin_model_i (.sys_clk, .a_out, .a_oe, .c_out, .c_oe,
        .t_out, .t_oe, .t_pull(pull_on), .a_ext, .c_ext, .t_ext, .t_ext_on,
        .a_lvl(a_in), .c_lvl(c_in), .t_lvl(t_in));

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_total = err_total + 1;
            final_report();
        end
    end
    task final_report();
        $display("mismatches %0d, compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one single transfer; entered right after a rising edge
    task xfer(input logic [9:0] idx, input logic wr, input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, idx, 2'h0};
        hwrite <= wr;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer
    function logic [7:0] mix(input logic [7:0] d, l, p);
        return (d & l) | (~d & p);
    endfunction : mix

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        for (int p = 0; p < 3; p++) begin
            xfer(10'h005 + p, 1'b0, 8'h00);
            chk("dir after reset", 32'h0, rd);
        end
        for (int n = 0; n < 40; n++) begin
            v = $random(seed);
            v2 = $random(seed);
            {lat, dir, pu} = v[23:0];
            a_ext <= v[31:24];
            c_ext <= v[29:24];
            t_ext <= v[31:24];
            // only pulled-up pins may float, so their level is known
            t_ext_on <= v2[23:16] | ~pu;
            sel <= v2[4:0];
            psa <= v2[5] ? 3'h7 : v2[8:6];
            psb <= v2[9] ? 3'h7 : v2[12:10];
            for (int p = 0; p < 3; p++) begin
                xfer(10'h001 + p, 1'b1, lat);
                xfer(10'h005 + p, 1'b1, p == 1 ? dir & 8'h3F : dir);
            end
            xfer(10'h008, 1'b1, pu);
            chk("response", 32'h0, {31'h0, hresp});
            // pullup flop, two sync stages and the timer clock flop
            repeat (5) @(posedge sys_clk);
            #1;
            claim = (sel < 5'h08) ? 8'h01 << sel[2:0] : 8'h00;
            tlev = mix(dir, lat, (t_ext_on & t_ext) | ~t_ext_on);
            chk("converter pin", claim, conv);
            chk("analog oe", dir & ~claim, a_oe);
            chk("clock oe", dir[5:0], c_oe);
            chk("timer oe", dir, t_oe);
            chk("pin outs", {lat, lat[5:0], lat}, {a_out, c_out, t_out});
            chk("pullup", pu & ~dir, pull_on);
            chk("timer a clk", psa == 3'h7 && tlev[6], ta_clk);
            chk("timer b clk", psb == 3'h7 && tlev[4], tb_clk);
            xfer(10'h001, 1'b0, 8'h00);
            chk("analog read", mix(dir, lat, a_ext), rd);
            xfer(10'h002, 1'b0, 8'h00);
            chk("clock read", mix(dir, lat, a_ext) & 8'h3F, rd);
            xfer(10'h003, 1'b0, 8'h00);
            chk("timer read", tlev, rd);
            xfer(10'h006, 1'b0, 8'h00);
            chk("clock dir", dir & 8'h3F, rd);
        end
        xfer(10'h004, 1'b1, 8'hFF);
        xfer(10'h004, 1'b0, 8'h00);
        chk("unmapped read", 32'h0, rd);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1 chk("oe after reset", 32'h0, {a_oe, c_oe, t_oe});
        for (int p = 0; p < 3; p++) begin
            xfer(10'h005 + p, 1'b1, 8'hFF);
            xfer(10'h001 + p, 1'b0, 8'h00);
            chk("latch kept", p == 1 ? lat & 8'h3F : lat, rd);
        end
        xfer(10'h006, 1'b1, 8'h80);
        repeat (2) @(posedge sys_clk);
        #1 chk("clkout oe", 1'b1, c_oe[2]);
        chk("clkout high", 1'b1, c_out[2]);
        @(negedge sys_clk) #1 chk("clkout low", 1'b0, c_out[2]);
        @(posedge sys_clk);
        xfer(10'h006, 1'b0, 8'h00);
        chk("clkout enable", 32'h80, rd);
        xfer(10'h006, 1'b1, 8'h00);
        repeat (2) @(posedge sys_clk);
        chk("pin2 plain", {1'b0, lat[2]}, {c_oe[2], c_out[2]});
        final_report();
    end
endmodule : gpio_ports_bcd_tb
